// ### logic/gscr_pkg.sv
// Package for the galvo scanner per-axis command register bank.
// Assumes a single 40 MHz AHB-Lite clock; all offsets are byte addresses.
package gscr_pkg;
  // Register map, four axis channels of four words each
  localparam logic [7:0] OFS_CMD      = 8'h00; // Command value
  localparam logic [7:0] OFS_CORR     = 8'h04; // Position correction
  localparam logic [7:0] OFS_READBACK = 8'h08; // Interpolated readback
  localparam logic [7:0] OFS_STATUS   = 8'h0C; // Scanner status
  localparam logic [7:0] OFS_CTRL     = 8'h40; // Mode and format control
  localparam int         CHAN_STRIDE  = 16;    // Bytes per channel
  localparam int         NUM_CHAN     = 4;     // Channels 0..3
  // Control register fields
  localparam int         CTRL_PROTO_BIT = 16;  // 0 classic, 1 enhanced
  localparam int         CTRL_FMT_LSB   = 14;  // Position format select
  localparam int         CTRL_FTYPE_LSB = 11;  // Frame type code
  localparam logic [31:0] CTRL_RESET    = 32'h0000_0800; // Frame type 001
  // Position format codes
  localparam logic [1:0] FMT_16 = 2'h0;
  localparam logic [1:0] FMT_18 = 2'h1;
  localparam logic [1:0] FMT_20 = 2'h2;
  // Frame type codes
  localparam logic [2:0] FTYPE_POS  = 3'h1;
  localparam logic [2:0] FTYPE_CTRL = 3'h7;
  // Interpolation refresh period
  localparam int         REFRESH_NS     = 10000;
  localparam int         CLK_NS         = 25;
  localparam int         REFRESH_CYCLES = REFRESH_NS / CLK_NS;
  localparam int         STATUS_BITS    = 20;  // Status word plus parity
  localparam logic [31:0] REG_RESET     = 32'h0000_0000;
endpackage : gscr_pkg

// ### logic/gscr_regs.sv
// Per-axis command, correction, readback and status registers.
// Assumes AHB-Lite single-word transfers and asynchronous link pins.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Classic mode command position in bits 31:8
// - Enhanced mode: frame type picks position/command
// - Correction register holds offset in 31:8
// - Readback shows interpolation every 10 us
// - Readback captured before correction is added
// - Enhanced readback shows scanner reply data
// - Readback and status ignore host writes
// - Classic status word in bits 31:13
// - Parity stored in bit 12 unchecked
// - Channels 0..2 are X,Y,Z; 3 unused
// - Status on channels 0 and 2 only
// - Format 00/01/10 = 16/18/20 bits, 11 banned
module gscr_regs
(
  input  wire logic        hclk,        // System clock
  input  wire logic        hresetn,     // Async reset, active low
  input  wire logic        hsel,        // Slave select
  input  wire logic [31:0] haddr,       // Byte address
  input  wire logic [1:0]  htrans,      // Transfer type
  input  wire logic        hwrite,      // Write strobe
  input  wire logic [2:0]  hsize,       // Transfer size
  input  wire logic        hready,      // Bus ready in
  input  wire logic [31:0] hwdata,      // Write data
  output logic [31:0]      hrdata,      // Read data
  output logic             hreadyout,   // Slave ready
  output logic             hresp,       // Response, always OKAY
  input  wire logic        link_clk,    // Scanner link clock pin
  input  wire logic        link_sync,   // Scanner frame sync pin
  input  wire logic        stat_xy,     // XY status data pin
  input  wire logic        stat_z,      // Z status data pin
  input  wire logic [23:0] reply_data,  // Enhanced reply data, per frame
  input  wire logic        reply_vld,   // Reply strobe, hclk domain
  output logic [2:0]       frame_type,  // Frame type to serialiser
  output logic             proto_enh,   // Enhanced protocol selected
  output logic [1:0]       pos_format,  // Position format select
  output logic [71:0]      axis_out     // Compensated positions X,Y,Z; raw command words in enhanced mode
);
  import gscr_pkg::*;

  // Register storage
  logic [31:0] axis_command_value         [NUM_CHAN]; // Host commands
  logic [31:0] axis_position_correction   [NUM_CHAN]; // Host offsets
  logic [31:0] axis_interpolated_readback [NUM_CHAN]; // Readback
  logic [31:0] axis_scanner_status        [NUM_CHAN]; // Scanner status
  logic [31:0] ctrl;                                  // Control register
  logic [23:0] interp [NUM_CHAN];                     // Interpolators

  // Bus pipeline
  logic        ph_wr;   // Pending write data phase
  logic [7:0]  ph_addr; // Latched address
  logic        ph_ok;   // Latched address in range

  // Synchronisers and link edge
  logic [1:0]  clk_s, sync_s, xy_s, z_s; // Two-flop chains
  logic        clk_d;                     // Last synced clock
  logic        link_rise;                 // Link rising edge pulse

  // Refresh divider
  logic [8:0]  div;    // Refresh counter
  logic        tick;   // One pulse per 10 us

  // Receiver results
  logic [19:0] xy_word, z_word; // Status words
  logic        xy_vld, z_vld;   // New word strobes

  // Field decoder shared by writes and reads
  function automatic logic [1:0] chan_of(input logic [7:0] a);
    chan_of = a[5:4];
  endfunction
  function automatic logic [3:0] kind_of(input logic [7:0] a);
    kind_of = a[3:0];
  endfunction

  // Address phase capture
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ph_wr   <= 1'b0;
      ph_addr <= 8'h00;
      ph_ok   <= 1'b0;
    end
    else if (hready)
    begin
      // Wait states of other slaves stretch the phase
      ph_wr   <= hsel && htrans[1] && hwrite;
      ph_addr <= haddr[7:0];
      ph_ok   <= (haddr[31:8] == 24'h000000) && (hsize == 3'h2);
    end
  end

  // Always ready, always OKAY
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
    else
    begin
      // No wait state: every register answers at once
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // Control register write
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      ctrl <= CTRL_RESET;
    else if (ph_wr && ph_ok && ph_addr == OFS_CTRL)
    begin
      // Format 11 refused, old format kept
      if (hwdata[CTRL_FMT_LSB +: 2] == 2'h3)
        ctrl <= {hwdata[31:16], ctrl[15:14], hwdata[13:0]};
      else
        ctrl <= hwdata;
    end
  end

  // Writable per-axis registers, low byte forced zero
  generate
    for (genvar c = 0; c < NUM_CHAN; c++)
    begin : g_wr
      always_ff @(posedge hclk or negedge hresetn)
      begin
        if (!hresetn)
        begin
          axis_command_value[c]       <= REG_RESET;
          axis_position_correction[c] <= REG_RESET;
        end
        else if (ph_wr && ph_ok && ph_addr < OFS_CTRL
                 && chan_of(ph_addr) == 2'(c))
        begin
          if (kind_of(ph_addr) == OFS_CMD[3:0])
            axis_command_value[c] <= {hwdata[31:8], 8'h00};
          if (kind_of(ph_addr) == OFS_CORR[3:0])
            axis_position_correction[c] <= {hwdata[31:8], 8'h00};
        end
      end
    end
  endgenerate

  // Link pin synchronisers
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      clk_s  <= 2'h0;
      sync_s <= 2'h0;
      xy_s   <= 2'h0;
      z_s    <= 2'h0;
      clk_d  <= 1'b0;
    end
    else
    begin
      clk_s  <= {clk_s[0], link_clk};
      sync_s <= {sync_s[0], link_sync};
      xy_s   <= {xy_s[0], stat_xy};
      z_s    <= {z_s[0], stat_z};
      clk_d  <= clk_s[1];
    end
  end
  // Edge taken past the chain, never from the first flop
  assign link_rise = clk_s[1] && !clk_d;

  // Status receivers for XY and Z
  gscr_status_rx u_rx_xy
  (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .link_rise (link_rise),
    .link_sync (sync_s[1]),
    .link_data (xy_s[1]),
    .word      (xy_word),
    .word_vld  (xy_vld)
  );
  gscr_status_rx u_rx_z
  (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .link_rise (link_rise),
    .link_sync (sync_s[1]),
    .link_data (z_s[1]),
    .word      (z_word),
    .word_vld  (z_vld)
  );

  // Status registers: hardware only, bus writes have no path
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      axis_scanner_status[0] <= REG_RESET;
      axis_scanner_status[1] <= REG_RESET;
      axis_scanner_status[2] <= REG_RESET;
      axis_scanner_status[3] <= REG_RESET;
    end
    // Enhanced mode leaves the last status frozen
    else if (!ctrl[CTRL_PROTO_BIT])
    begin
      // Status 31:13, parity 12 unchecked
      if (xy_vld)
        axis_scanner_status[0] <= {xy_word, 12'h000};
      if (z_vld)
        axis_scanner_status[2] <= {z_word, 12'h000};
    end
  end

  // Refresh divider, one tick every 10 us
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      div  <= 9'h000;
      tick <= 1'b0;
    end
    // Free running; first tick one period after reset
    else if (div == 9'(REFRESH_CYCLES - 1))
    begin
      div  <= 9'h000;
      tick <= 1'b1;
    end
    else
    begin
      div  <= div + 9'h001;
      tick <= 1'b0;
    end
  end

  // Halving interpolation toward command, readback before correction
  generate
    for (genvar c = 0; c < NUM_CHAN; c++)
    begin : g_ip
      logic [23:0] tgt;   // Command target
      logic [23:0] diff;  // Remaining distance
      assign tgt  = axis_command_value[c][31:8];
      assign diff = tgt - interp[c];
      always_ff @(posedge hclk or negedge hresetn)
      begin
        if (!hresetn)
        begin
          interp[c] <= 24'h000000;
          axis_interpolated_readback[c] <= REG_RESET;
        end
        else if (c == 3)
        begin
          // Channel 3 unused
          axis_interpolated_readback[c] <= REG_RESET;
        end
        else if (ctrl[CTRL_PROTO_BIT])
        begin
          // Enhanced: latest scanner reply
          if (reply_vld)
            axis_interpolated_readback[c] <= {reply_data, 8'h00};
        end
        else if (tick)
        begin
          // Halve remaining distance each period, then snap
          // Arithmetic half step keeps the sign of the distance
          if (diff[23:1] == 23'h000000 || &diff[23:1])
            interp[c] <= tgt;
          else
            interp[c] <= interp[c] + {diff[23], diff[23:1]};
          axis_interpolated_readback[c] <= {interp[c], 8'h00};
        end
      end
    end
  endgenerate

  // Compensated positions and mode to the serialiser
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      axis_out   <= 72'h0;
      frame_type <= FTYPE_POS;
      proto_enh  <= 1'b0;
      pos_format <= FMT_16;
    end
    else
    begin
      // X in bits 23:0, Y in 47:24, Z in 71:48
      for (int c = 0; c < 3; c++)
      begin
        if (ctrl[CTRL_PROTO_BIT])
          // Raw upper 24 bits, meaning set by frame type
          axis_out[c*24 +: 24] <= axis_command_value[c][31:8];
        else
          // Correction added after readback capture
          axis_out[c*24 +: 24] <= interp[c]
                                  + axis_position_correction[c][31:8];
      end
      frame_type <= ctrl[CTRL_FTYPE_LSB +: 3];
      proto_enh  <= ctrl[CTRL_PROTO_BIT];
      pos_format <= ctrl[CTRL_FMT_LSB +: 2];
    end
  end

  // Read data, registered in the address phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h0000_0000;
    else if (hready && hsel && htrans[1] && !hwrite)
    begin
      // Outside the 256-byte window reads zero
      if (haddr[31:8] != 24'h000000)
        hrdata <= 32'h0000_0000;
      else if (haddr[7:0] == OFS_CTRL)
        hrdata <= ctrl;
      // Gap above the control word reads zero
      else if (haddr[7:0] > OFS_CTRL)
        hrdata <= 32'h0000_0000;
      else
      begin
        unique case (kind_of(haddr[7:0]))
          OFS_CMD[3:0]:
            hrdata <= axis_command_value[chan_of(haddr[7:0])];
          OFS_CORR[3:0]:
            hrdata <= axis_position_correction[chan_of(haddr[7:0])];
          OFS_READBACK[3:0]:
            hrdata <= axis_interpolated_readback[chan_of(haddr[7:0])];
          OFS_STATUS[3:0]:
            hrdata <= axis_scanner_status[chan_of(haddr[7:0])];
          default:
            hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule // gscr_regs
`default_nettype wire

// ### logic/gscr_status_rx.sv
// Serial receiver for one scanner status channel.
// Assumes link clock and data already synchronised to hclk.
`timescale 1ns/1ps
`default_nettype none
module gscr_status_rx
(
  input  wire logic        hclk,      // System clock
  input  wire logic        hresetn,   // Async reset, active low
  input  wire logic        link_rise, // Link clock rising edge pulse
  input  wire logic        link_sync, // Synchronised frame sync
  input  wire logic        link_data, // Synchronised status data
  output logic [19:0]      word,      // Status word and parity
  output logic             word_vld   // One-cycle pulse on new word
);
  import gscr_pkg::*;
  logic [19:0] shift;  // Shift register
  logic [4:0]  count;  // Bits shifted this frame

  // Shift on link edges while sync high, publish on sync end
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      shift    <= 20'h00000;
      count    <= 5'h00;
      word     <= 20'h00000;
      word_vld <= 1'b0;
    end
    else
    begin
      word_vld <= 1'b0;
      if (link_rise)
      begin
        if (link_sync)
        begin
          shift <= {shift[18:0], link_data};
          if (count != 5'h1F)
            count <= count + 5'h01;
        end
        else
        begin
          // Frame complete when enough bits arrived
          if (count >= 5'(STATUS_BITS))
          begin
            word     <= shift;
            word_vld <= 1'b1;
          end
          count <= 5'h00;
        end
      end
    end
  end
endmodule // gscr_status_rx
`default_nettype wire

// ### verification/gscr_regs_sva.sv
// Checker for the galvo scanner command register bank.
// Assumes zero-wait AHB-Lite with hready fed from hreadyout.
`timescale 1ns/1ps
`default_nettype none
module gscr_regs_sva
(
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hwdata,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        proto_enh,
  input wire logic [1:0]  pos_format
);
  logic        rd; // Read data phase
  logic        wr; // Write data phase
  logic [31:0] pa; // Address of the data phase
  logic [31:0] cw; // Last legal control write
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Follow the address phase into its data phase
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      rd <= 1'b0;
      wr <= 1'b0;
      pa <= 32'h0;
    end
    else if (hready)
    begin
      rd <= hsel && htrans[1] && !hwrite;
      wr <= hsel && htrans[1] && hwrite;
      pa <= haddr;
    end
  // Remember control writes that carry a legal format
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      cw <= 32'h0000_0800;
    else if (wr && pa == 32'h40 && hwdata[15:14] != 2'h3)
      cw <= hwdata;
  a_ready_high: assert property (hreadyout)
    else $error("slave not ready");
  a_resp_okay: assert property (!hresp)
    else $error("error response");
  a_low_byte_zero: assert property (
    rd && pa < 32'h40 |-> hrdata[7:0] == 8'h00)
    else $error("low byte not zero");
  a_status_tail_zero: assert property (
    rd && pa < 32'h40 && pa[3:0] == 4'hC |-> hrdata[11:0] == 12'h000)
    else $error("status tail not zero");
  a_unused_status: assert property (
    rd && (pa == 32'h1C || pa == 32'h3C) |-> hrdata == 32'h0)
    else $error("unused status not zero");
  a_ch3_readback: assert property (
    rd && pa == 32'h38 |-> hrdata == 32'h0)
    else $error("channel 3 readback not zero");
  a_unmapped_zero: assert property (rd && pa > 32'h40 |-> hrdata == 32'h0)
    else $error("unmapped read not zero");
  a_format_legal: assert property (pos_format != 2'h3)
    else $error("format code 11 seen");
  a_format_follow: assert property (
    wr && pa == 32'h40 && hwdata[15:14] != 2'h3 |->
    ##2 pos_format == cw[15:14] && proto_enh == cw[16])
    else $error("control copy wrong");
endmodule // gscr_regs_sva
bind gscr_regs gscr_regs_sva u_sva
(
  .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready,
  .hwdata, .hrdata, .hreadyout, .hresp, .proto_enh, .pos_format
);
`default_nettype wire

// ### verification/gscr_regs_test.sv
// Self-checking bench for the galvo scanner command register bank.
// Assumes zero-wait slave; scanner model drives the link pins.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin errors++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end
module gscr_regs_test;
  import gscr_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, reply_vld;
  logic        link_clk, link_sync, stat_xy, stat_z, proto_enh;
  logic [1:0]  htrans, pos_format;
  logic [2:0]  hsize, frame_type;
  logic [31:0] haddr, hwdata, hrdata, rdata, r;
  logic [23:0] reply_data, rply;
  logic [23:0] cmd [3];
  logic [23:0] corr [3];
  logic [19:0] sw [2];
  logic [71:0] axis_out;
  wire logic   hready, hreadyout, hresp;
  int          errors, cmp_count;
  localparam logic [31:0] RO [6] = '{32'hC, 32'h1C, 32'h2C, 32'h38,
                                     32'h44, 32'h100};
  localparam logic [2:0] FT [2] = '{FTYPE_POS, FTYPE_CTRL};
  assign hready = hreadyout; // Single slave
  gscr_regs DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .link_clk(link_clk),
    .link_sync(link_sync), .stat_xy(stat_xy), .stat_z(stat_z),
    .reply_data(reply_data), .reply_vld(reply_vld),
    .frame_type(frame_type), .proto_enh(proto_enh),
    .pos_format(pos_format), .axis_out(axis_out));
  gscr_scanner_model u_scn (.link_clk(link_clk), .link_sync(link_sync),
    .stat_xy(stat_xy), .stat_z(stat_z));
  // Expected register images
  function automatic logic [31:0] pos_word(input logic [23:0] p);
    return {p, 8'h00};
  endfunction
  function automatic logic [31:0] stat_word(input logic [19:0] w);
    return {w, 12'h000};
  endfunction
  // Clock, 25 ns period
  initial
  begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end
  // One single-word transfer, entered just after a rising edge
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    hsize <= 3'h2;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    q = hrdata;
  endtask
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Watchdog
  initial
  begin
    repeat (40000) @(posedge hclk);
    errors++;
    tally_and_finish();
  end
  initial
  begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    reply_data = 24'h0;
    reply_vld = 1'b0;
    void'($urandom(32'hBDD4BF35));
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (int a = 0; a < 16; a++)
    begin
      ahb(1'b0, a * 4, 32'h0, rdata);
      `CHK(rdata, REG_RESET)
    end
    ahb(1'b0, 32'h40, 32'h0, rdata);
    `CHK(rdata, CTRL_RESET)
    $display("reset test done");
    // Extreme and random positions, small corrections
    for (int c = 0; c < 3; c++)
    begin
      r = $urandom;
      cmd[c] = (c == 0) ? 24'h800000 : (c == 1) ? 24'h7FF000 :
               {{2{r[21]}}, r[21:0]};
      corr[c] = 24'($urandom_range(1, 4095));
      ahb(1'b1, c * 16, pos_word(cmd[c]), rdata);
      ahb(1'b1, c * 16 + 4, pos_word(corr[c]), rdata);
      ahb(1'b0, c * 16, 32'h0, rdata);
      `CHK(rdata, pos_word(cmd[c]))
      ahb(1'b0, c * 16 + 4, 32'h0, rdata);
      `CHK(rdata, pos_word(corr[c]))
    end
    $display("command test done");
    repeat (40 * REFRESH_CYCLES) @(posedge hclk);
    for (int c = 0; c < 3; c++)
    begin
      ahb(1'b0, c * 16 + 8, 32'h0, rdata);
      `CHK(rdata, pos_word(cmd[c]))
      `CHK(axis_out[c * 24 +: 24], cmd[c] + corr[c])
    end
    $display("interpolation test done");
    // Read-only, unused and unmapped places ignore writes
    for (int i = 0; i < 6; i++)
    begin
      ahb(1'b1, RO[i], 32'hFFFF_FF00, rdata);
      ahb(1'b0, RO[i], 32'h0, rdata);
      `CHK(rdata, 32'h0)
    end
    ahb(1'b1, 32'h8, 32'hFFFF_FF00, rdata);
    ahb(1'b0, 32'h8, 32'h0, rdata);
    `CHK(rdata, pos_word(cmd[0]))
    $display("read-only test done");
    for (int i = 0; i < 2; i++)
    begin
      sw[0] = (i == 0) ? 20'($urandom) : 20'h00001;
      sw[1] = 20'($urandom);
      u_scn.send(sw[0], sw[1]);
      repeat (8) @(posedge hclk);
      ahb(1'b0, 32'hC, 32'h0, rdata);
      `CHK(rdata, stat_word(sw[0]))
      ahb(1'b0, 32'h2C, 32'h0, rdata);
      `CHK(rdata, stat_word(sw[1]))
      ahb(1'b0, 32'h1C, 32'h0, rdata);
      `CHK(rdata, 32'h0)
    end
    $display("status test done");
    // Every format with frame types 001 and 111 only in enhanced mode
    for (int f = 0; f < 3; f++)
      for (int t = 0; t < 2; t++)
      begin
        ahb(1'b1, 32'h40, {15'h0, 1'b1, 2'(f), FT[t], 11'h0}, rdata);
        // Host keeps the word inside the enhanced range
        r = $urandom;
        cmd[1] = (r[23:0] == 24'h800000) ? 24'h7FFFFF : r[23:0];
        ahb(1'b1, 32'h10, pos_word(cmd[1]), rdata);
        repeat (2) @(posedge hclk);
        r = {26'h0, proto_enh, pos_format, frame_type};
        `CHK(r[5:0], {1'b1, 2'(f), FT[t]})
        `CHK(axis_out[47:24], cmd[1])
      end
    ahb(1'b1, 32'h40, {15'h0, 1'b1, 2'h3, FTYPE_CTRL, 11'h0}, rdata);
    repeat (2) @(posedge hclk);
    `CHK(pos_format, FMT_20)
    rply = 24'($urandom);
    reply_data <= rply;
    reply_vld <= 1'b1;
    @(posedge hclk);
    reply_vld <= 1'b0;
    @(posedge hclk);
    for (int c = 0; c < 3; c++)
    begin
      ahb(1'b0, c * 16 + 8, 32'h0, rdata);
      `CHK(rdata, pos_word(rply))
    end
    $display("enhanced test done");
    tally_and_finish();
  end
endmodule // gscr_regs_test
`default_nettype wire

// ### verification/gscr_scanner_model.sv
// Scanner head model sending status frames on the link pins.
// Assumes a 200 ns link clock that stands still between frames.
`timescale 1ns/1ps
`default_nettype none
module gscr_scanner_model
(
  output logic link_clk,  // Link clock, idle low
  output logic link_sync, // Frame sync
  output logic stat_xy,   // XY status line
  output logic stat_z     // Z status line
);
  initial
  begin
    link_clk = 1'b0;
    link_sync = 1'b0;
    stat_xy = 1'b0;
    stat_z = 1'b0;
  end
  // One frame, MSB first, parity last and never checked
  task automatic send(input logic [19:0] xy, input logic [19:0] z);
    #7;
    for (int i = 19; i >= 0; i--)
    begin
      stat_xy = xy[i];
      stat_z = z[i];
      link_sync = 1'b1;
      #100 link_clk = 1'b1;
      #100 link_clk = 1'b0;
    end
    // Closing edge with sync low; lines show the inverse once released
    link_sync = 1'b0;
    stat_xy = ~stat_xy;
    stat_z = ~stat_z;
    #100 link_clk = 1'b1;
    #100 link_clk = 1'b0;
  endtask
endmodule // gscr_scanner_model
`default_nettype wire
